// ===== cri_consts.vh
`ifndef CRI_CONSTS_VH
`define CRI_CONSTS_VH
// ==========================================================
// Slot layout (byte offsets within one 12-byte slot)
`define CRI_SLOT_BYTES      16'h000c
`define CRI_W_CTRL          16'h0000
`define CRI_W_BLK_LOC       16'h0002
`define CRI_W_TAG_HI        16'h0004
`define CRI_W_TAG_LO        16'h0006
`define CRI_W_LEN_Q         16'h0008
`define CRI_W_RSVD          16'h000a
// ==========================================================
// Control word fields
`define CRI_LAUNCH_BIT      0
`define CRI_ABORT_ACK_BIT   1
`define CRI_URGENT_BIT      2
`define CRI_REMOTE_BIT      4
`define CRI_QUEUE_MAX       4'he
// ==========================================================
// Own command registers (word addresses)
`define CRI_R_CTRL          4'h0
`define CRI_R_RING_BASE     4'h1
`define CRI_R_RING_COUNT    4'h2
`define CRI_R_MASTER_BASE   4'h3
`define CRI_R_BLK_LOC       4'h4
`define CRI_R_TAG_HI        4'h5
`define CRI_R_TAG_LO        4'h6
`define CRI_R_LEN_Q         4'h7
`define CRI_R_FLAGS         4'h8
`define CRI_R_STATUS        4'h9
`define CRI_R_SLOT_IDX      4'ha
// ==========================================================
// Reset values
`define CRI_RST_RING_BASE   16'h0000
`define CRI_RST_RING_COUNT  16'h0001
`define CRI_RST_MASTER_BASE 16'h0000
// ==========================================================
// Timing: launch poll interval
`define CRI_POLL_NS         1000
`define CRI_CLK_NS          10
`define CRI_POLL_CYC        (`CRI_POLL_NS / `CRI_CLK_NS)
`endif

// ===== cri_poll_tick.v
`timescale 1ns/1ps
`include "cri_consts.vh"
// ==========================================================
// Poll divider: one-cycle enable pulse
module cri_poll_tick #(
   parameter CYCLES = `CRI_POLL_CYC
) (
   ref_clk,
   rst_b,
   tick
);
   input  wire        ref_clk;
   input  wire        rst_b;
   output reg         tick;
   reg    [15:0]      cnt_r;
   always @(posedge ref_clk) begin
      if (!rst_b) begin
         cnt_r <= 16'h0000;
         tick  <= 1'b0;
      end else if (cnt_r == CYCLES[15:0] - 16'h0001) begin
         cnt_r <= 16'h0000;
         tick  <= 1'b1;
      end else begin
         cnt_r <= cnt_r + 16'h0001;
         tick  <= 1'b0;
      end
   end
endmodule

// ===== cri_slot_ptr.v
`timescale 1ns/1ps
`include "cri_consts.vh"
// ==========================================================
// Circular slot index and slot byte address
module cri_slot_ptr (
   ref_clk,
   rst_b,
   clear,
   advance,
   count,
   base,
   idx,
   addr
);
   input  wire        ref_clk;
   input  wire        rst_b;
   input  wire        clear;
   input  wire        advance;
   input  wire [15:0] count;
   input  wire [15:0] base;
   output reg  [15:0] idx;
   output wire [15:0] addr;
   wire   [31:0]      prod;
   assign prod = idx * `CRI_SLOT_BYTES;
   assign addr = base + prod[15:0];
   always @(posedge ref_clk) begin
      if (!rst_b || clear) begin
         idx <= 16'h0000;
      end else if (advance) begin
         // Wrap keeps circular fill order
         if (idx + 16'h0001 >= count)
            idx <= 16'h0000;
         else
            idx <= idx + 16'h0001;
      end
   end
endmodule

// ===== cri_host.v
// The placing of the registers and the address-and-strobe port were decided locally.
`timescale 1ns/1ps
`include "cri_consts.vh"
module cri_host #(
   parameter POLL_CYCLES = `CRI_POLL_CYC
) (
   ref_clk,
   rst_b,
   sw_addr,
   sw_wdata,
   sw_wr,
   sw_rd,
   sw_rdata,
   mem_addr,
   mem_wdata,
   mem_wr,
   mem_rd,
   mem_rdata
);
   input  wire        ref_clk;
   input  wire        rst_b;
   input  wire [3:0]  sw_addr;
   input  wire [15:0] sw_wdata;
   input  wire        sw_wr;
   input  wire        sw_rd;
   output reg  [15:0] sw_rdata;
   output reg  [15:0] mem_addr;
   output reg  [15:0] mem_wdata;
   output reg         mem_wr;
   output reg         mem_rd;
   input  wire [15:0] mem_rdata;

   // ==========================================================
   // States
   localparam S_IDLE   = 8'b00000001;
   localparam S_CHKRD  = 8'b00000010;
   localparam S_CHKWT  = 8'b00000100;
   localparam S_HOLD   = 8'b00001000;
   localparam S_WRITE  = 8'b00010000;
   localparam S_LAUNCH = 8'b00100000;
   localparam S_WAITP  = 8'b01000000;
   localparam S_DONE   = 8'b10000000;

   reg    [7:0]       st_r;
   reg                queued_r;
   reg    [15:0]      ring_base_r;
   reg    [15:0]      ring_count_r;
   reg    [15:0]      master_base_r;
   reg    [15:0]      blk_loc_r;
   reg    [15:0]      tag_hi_r;
   reg    [15:0]      tag_lo_r;
   reg    [15:0]      len_q_r;
   reg                f_abort_r;
   reg                f_urgent_r;
   reg                f_remote_r;
   reg                pend_r;
   reg                busy_r;
   reg                full_r;
   reg                done_r;
   reg                bad_r;
   reg                use_master_r;
   reg    [2:0]       widx_r;
   reg    [15:0]      slot_addr_r;
   wire   [15:0]      ring_idx;
   wire   [15:0]      ring_addr;
   wire               tick;
   wire               advance;
   wire   [15:0]      ctrl_word;
   wire               go_wr;

   // ==========================================================
   // Control word build
   function [15:0] cri_ctrl;
      input remote;
      input abort_ack;
      input urgent;
      begin
         cri_ctrl = 16'h0000;
         cri_ctrl[`CRI_LAUNCH_BIT] = 1'b1;
         if (remote) begin
            // Other bits are ignored in remote mode, so keep them clear
            cri_ctrl[`CRI_REMOTE_BIT] = 1'b1;
         end else begin
            cri_ctrl[`CRI_ABORT_ACK_BIT] = abort_ack;
            cri_ctrl[`CRI_URGENT_BIT] = urgent;
         end
      end
   endfunction

   // ==========================================================
   // Byte address of one word of the current slot
   function [15:0] cri_word_addr;
      input [15:0] slot;
      input [15:0] off;
      begin
         cri_word_addr = slot + off;
      end
   endfunction

   assign ctrl_word = cri_ctrl(f_remote_r, f_abort_r, f_urgent_r);
   assign go_wr = sw_wr && (sw_addr == `CRI_R_CTRL) && sw_wdata[0] && !busy_r;
   assign advance = (st_r == S_LAUNCH) && !use_master_r;

   cri_poll_tick #(
      .CYCLES (POLL_CYCLES)
   ) u_tick (
      .ref_clk (ref_clk),
      .rst_b   (rst_b),
      .tick    (tick)
   );

   cri_slot_ptr u_ptr (
      .ref_clk (ref_clk),
      .rst_b   (rst_b),
      .clear   (sw_wr && sw_addr == `CRI_R_RING_COUNT),
      .advance (advance),
      .count   (ring_count_r),
      .base    (ring_base_r),
      .idx     (ring_idx),
      .addr    (ring_addr)
   );

   // ==========================================================
   // Software registers
   always @(posedge ref_clk) begin
      if (!rst_b) begin
         sw_rdata      <= 16'h0000;
         queued_r      <= 1'b0;
         ring_base_r   <= `CRI_RST_RING_BASE;
         ring_count_r  <= `CRI_RST_RING_COUNT;
         master_base_r <= `CRI_RST_MASTER_BASE;
         blk_loc_r     <= 16'h0000;
         tag_hi_r      <= 16'h0000;
         tag_lo_r      <= 16'h0000;
         len_q_r       <= 16'h0000;
         f_abort_r     <= 1'b0;
         f_urgent_r    <= 1'b0;
         f_remote_r    <= 1'b0;
      end else begin
         if (sw_wr) begin
            case (sw_addr)
               `CRI_R_CTRL:        queued_r <= sw_wdata[1];
               `CRI_R_RING_BASE:   ring_base_r <= sw_wdata;
               // Zero count would be illegal; clamp to one
               `CRI_R_RING_COUNT:  ring_count_r <= (sw_wdata == 16'h0000) ?
                                                   16'h0001 : sw_wdata;
               `CRI_R_MASTER_BASE: master_base_r <= sw_wdata;
               `CRI_R_BLK_LOC:     blk_loc_r <= sw_wdata;
               `CRI_R_TAG_HI:      tag_hi_r <= sw_wdata;
               `CRI_R_TAG_LO:      tag_lo_r <= sw_wdata;
               // Reserved bits 4..7 forced to zero
               `CRI_R_LEN_Q:       len_q_r <= {sw_wdata[15:8], 4'h0, sw_wdata[3:0]};
               `CRI_R_FLAGS: begin
                  f_abort_r  <= sw_wdata[0];
                  f_urgent_r <= sw_wdata[1];
                  f_remote_r <= sw_wdata[2];
               end
               default: ;
            endcase
         end
         if (sw_rd) begin
            case (sw_addr)
               `CRI_R_CTRL:        sw_rdata <= {15'h0000, queued_r};
               `CRI_R_RING_BASE:   sw_rdata <= ring_base_r;
               `CRI_R_RING_COUNT:  sw_rdata <= ring_count_r;
               `CRI_R_MASTER_BASE: sw_rdata <= master_base_r;
               `CRI_R_BLK_LOC:     sw_rdata <= blk_loc_r;
               `CRI_R_TAG_HI:      sw_rdata <= tag_hi_r;
               `CRI_R_TAG_LO:      sw_rdata <= tag_lo_r;
               `CRI_R_LEN_Q:       sw_rdata <= len_q_r;
               `CRI_R_FLAGS:       sw_rdata <= {13'h0000, f_remote_r, f_urgent_r,
                                                f_abort_r};
               `CRI_R_STATUS:      sw_rdata <= {12'h000, bad_r, done_r, full_r,
                                                busy_r};
               `CRI_R_SLOT_IDX:    sw_rdata <= ring_idx;
               default:            sw_rdata <= 16'h0000;
            endcase
         end else begin
            sw_rdata <= 16'h0000;
         end
      end
   end

   // ==========================================================
   // Go request; a new go wins over the clear in the same cycle
   always @(posedge ref_clk) begin
      if (!rst_b) begin
         pend_r <= 1'b0;
      end else if (go_wr) begin
         pend_r <= 1'b1;
      end else if (st_r == S_IDLE) begin
         // Cleared on a refused queue too, so no stale go survives
         pend_r <= 1'b0;
      end
   end

   // ==========================================================
   // Issue sequencer
   always @(posedge ref_clk) begin
      if (!rst_b) begin
         st_r         <= S_IDLE;
         mem_addr     <= 16'h0000;
         mem_wdata    <= 16'h0000;
         mem_wr       <= 1'b0;
         mem_rd       <= 1'b0;
         busy_r       <= 1'b0;
         full_r       <= 1'b0;
         done_r       <= 1'b0;
         bad_r        <= 1'b0;
         use_master_r <= 1'b0;
         widx_r       <= 3'h0;
         slot_addr_r  <= 16'h0000;
      end else begin
         mem_wr <= 1'b0;
         mem_rd <= 1'b0;
         case (st_r)
            S_IDLE: begin
               if (pend_r) begin
                  busy_r <= 1'b1;
                  done_r <= 1'b0;
                  // Queue numbers above 0xE are refused
                  if (len_q_r[3:0] > `CRI_QUEUE_MAX) begin
                     bad_r  <= 1'b1;
                     busy_r <= 1'b0;
                  end else begin
                     bad_r <= 1'b0;
                     // Master slot until queued mode
                     use_master_r <= !queued_r;
                     slot_addr_r  <= queued_r ? ring_addr : master_base_r;
                     st_r         <= S_CHKRD;
                  end
               end
            end
            S_CHKRD: begin
               mem_addr <= cri_word_addr(slot_addr_r, `CRI_W_CTRL);
               mem_rd   <= 1'b1;
               st_r     <= S_CHKWT;
            end
            S_CHKWT: begin
               // Read data stands one cycle only, so look exactly once
               if (!mem_rd) begin
                  // Launch flag still set: slot in use, wait
                  if (mem_rdata[`CRI_LAUNCH_BIT]) begin
                     full_r <= 1'b1;
                     st_r   <= S_HOLD;
                  end else begin
                     full_r <= 1'b0;
                     widx_r <= 3'h0;
                     st_r   <= S_WRITE;
                  end
               end
            end
            S_HOLD: begin
               // Slot still owned: read again at the next poll tick
               if (tick)
                  st_r <= S_CHKRD;
            end
            S_WRITE: begin
               // Words 1..5 first; control word is last
               mem_wr <= 1'b1;
               case (widx_r)
                  3'h0: begin
                     mem_addr  <= cri_word_addr(slot_addr_r, `CRI_W_BLK_LOC);
                     mem_wdata <= blk_loc_r;
                  end
                  3'h1: begin
                     mem_addr  <= cri_word_addr(slot_addr_r, `CRI_W_TAG_HI);
                     mem_wdata <= tag_hi_r;
                  end
                  3'h2: begin
                     mem_addr  <= cri_word_addr(slot_addr_r, `CRI_W_TAG_LO);
                     mem_wdata <= tag_lo_r;
                  end
                  3'h3: begin
                     mem_addr  <= cri_word_addr(slot_addr_r, `CRI_W_LEN_Q);
                     mem_wdata <= len_q_r;
                  end
                  default: begin
                     mem_addr  <= cri_word_addr(slot_addr_r, `CRI_W_RSVD);
                     mem_wdata <= 16'h0000;
                  end
               endcase
               if (widx_r == 3'h4)
                  st_r <= S_LAUNCH;
               widx_r <= widx_r + 3'h1;
            end
            S_LAUNCH: begin
               // Next ring slot taken in circular order
               mem_wr    <= 1'b1;
               mem_addr  <= cri_word_addr(slot_addr_r, `CRI_W_CTRL);
               mem_wdata <= ctrl_word;
               st_r      <= S_WAITP;
            end
            S_WAITP: begin
               // Wait for the device to free the slot
               // No time limit: a device that never frees keeps busy up
               if (tick) begin
                  mem_addr <= cri_word_addr(slot_addr_r, `CRI_W_CTRL);
                  mem_rd   <= 1'b1;
                  st_r     <= S_DONE;
               end
            end
            S_DONE: begin
               if (!mem_rd) begin
                  if (mem_rdata[`CRI_LAUNCH_BIT]) begin
                     st_r <= S_WAITP;
                  end else begin
                     busy_r <= 1'b0;
                     done_r <= 1'b1;
                     st_r   <= S_IDLE;
                  end
               end
            end
            default: st_r <= S_IDLE;
         endcase
      end
   end
endmodule

// ===== cri_host_properties.sv
`timescale 1ns/1ps
// ====================
// Host side of the slot handshake
module cri_host_properties #(
   parameter POLL_CYCLES = 100
) (
   input logic        ref_clk,
   input logic        rst_b,
   input logic [3:0]  sw_addr,
   input logic [15:0] sw_wdata,
   input logic        sw_wr,
   input logic        sw_rd,
   input logic [15:0] sw_rdata,
   input logic [15:0] mem_addr,
   input logic [15:0] mem_wdata,
   input logic        mem_wr,
   input logic        mem_rd,
   input logic [15:0] mem_rdata
);
   localparam int PMAX = POLL_CYCLES + 4;
   logic [2:0]  wcnt_r;
   logic [15:0] wa_r;
   logic [15:0] ra_r;
   logic        rdd_r;
   logic        blk_r;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_b);
   // Sixth write is the launch; a flag read as set blocks all writes
   always @(posedge ref_clk) begin
      if (!rst_b) begin
         wcnt_r <= 3'h0;
         wa_r <= 16'h0000;
         ra_r <= 16'h0000;
         rdd_r <= 1'b0;
         blk_r <= 1'b0;
      end else begin
         rdd_r <= mem_rd;
         if (mem_rd) begin
            ra_r <= mem_addr;
         end
         if (mem_wr) begin
            wa_r <= mem_addr;
            wcnt_r <= (wcnt_r == 3'h5) ? 3'h0 : wcnt_r + 3'h1;
         end
         if (mem_wr && wcnt_r == 3'h5) begin
            blk_r <= 1'b1;
         end else if (rdd_r) begin
            blk_r <= mem_rdata[0];
         end
      end
   end
   rw_apart_a: assert property (!(mem_wr && mem_rd))
      else $error("memory read and write together");
   rd_pulse_a: assert property (mem_rd |=> !mem_rd)
      else $error("read strobe longer than one cycle");
   launch_last_a: assert property (
      mem_wr && wcnt_r == 3'h5 |-> mem_wdata[0] && mem_addr == wa_r - 16'h000a)
      else $error("launch word not last or flag clear");
   ctrl_rsvd_a: assert property (
      mem_wr && wcnt_r == 3'h5 |-> (mem_wdata & 16'hffe8) == 16'h0000)
      else $error("reserved control bits set");
   lenq_field_a: assert property (
      mem_wr && wcnt_r == 3'h3 |-> mem_wdata[7:4] == 4'h0 && mem_wdata[3:0] != 4'hf)
      else $error("bad length or queue word");
   slot_step_a: assert property (
      mem_wr && wcnt_r != 3'h5 |-> mem_addr == ((wcnt_r == 3'h0) ? ra_r : wa_r) + 16'h0002)
      else $error("slot word address out of order");
   busy_nowr_a: assert property (blk_r |-> !mem_wr)
      else $error("slot written while launched");
   busy_repoll_a: assert property (rdd_r && mem_rdata[0] |-> ##[1:PMAX] mem_rd)
      else $error("busy slot not polled again");
   rdata_idle_a: assert property (!$past(sw_rd) |-> sw_rdata == 16'h0000)
      else $error("read data outside its cycle");
   cover property (mem_wr && wcnt_r == 3'h5);
   cover property (rdd_r && mem_rdata[0]);
   cover property (sw_wr && sw_addr == 4'h0 && sw_wdata[0]);
endmodule
bind cri_host cri_host_properties #(.POLL_CYCLES(POLL_CYCLES)) cri_host_properties_inst (
   .ref_clk(ref_clk), .rst_b(rst_b), .sw_addr(sw_addr), .sw_wdata(sw_wdata),
   .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata), .mem_addr(mem_addr),
   .mem_wdata(mem_wdata), .mem_wr(mem_wr), .mem_rd(mem_rd), .mem_rdata(mem_rdata)
);

// ===== cri_dev.sv
`timescale 1ns/1ps
// ====================
// Device: shared memory that takes and frees launched slots
module cri_dev (
   input  logic        ref_clk,
   input  logic [7:0]  hold_cyc,
   input  logic [15:0] mem_addr,
   input  logic [15:0] mem_wdata,
   input  logic        mem_wr,
   input  logic        mem_rd,
   output logic [15:0] mem_rdata
);
   logic [15:0] mem [0:255];
   logic [15:0] copy_w [0:5];
   logic [15:0] wa_r = 16'h0000;
   logic [7:0]  lidx = 8'h00;
   logic [7:0]  wait_r = 8'h00;
   logic        pend_r = 1'b0;
   int          n_launch = 0;
   initial begin
      mem_rdata = 16'h5a5a;
      for (int i = 0; i < 256; i++) mem[i] = 16'h0000;
   end
   always @(posedge ref_clk) begin
      // Stale read data toggles so it can never pass for fresh
      if (mem_rd) begin
         mem_rdata <= mem[mem_addr[8:1]];
      end else begin
         mem_rdata <= ~mem_rdata;
      end
      if (mem_wr) begin
         mem[mem_addr[8:1]] <= mem_wdata;
         wa_r <= mem_addr;
      end
      if (mem_wr && mem_wdata[0] && mem_addr == wa_r - 16'h000a) begin
         pend_r <= 1'b1;
         lidx <= mem_addr[8:1];
         wait_r <= hold_cyc;
         n_launch <= n_launch + 1;
      end else if (pend_r && wait_r != 8'h00) begin
         wait_r <= wait_r - 8'h01;
      end else if (pend_r) begin
         for (int i = 0; i < 6; i++) copy_w[i] <= mem[lidx + i];
         mem[lidx] <= mem[lidx] & 16'hfffe;
         pend_r <= 1'b0;
      end
   end
endmodule

// ===== tb_top.sv
`timescale 1ns/1ps
`include "cri_consts.vh"
// ====================
// Host controller bench
module tb_top;
   logic        ref_clk = 1'b0;
   logic        rst_b = 1'b0;
   logic [3:0]  sw_addr = 4'h0;
   logic [15:0] sw_wdata = 16'h0000;
   logic        sw_wr = 1'b0;
   logic        sw_rd = 1'b0;
   logic [7:0]  hold_cyc = 8'h00;
   wire  [15:0] sw_rdata, mem_addr, mem_wdata, mem_rdata;
   wire         mem_wr, mem_rd;
   int          bad_count = 0;
   int          n_tests = 0;
   int          nl;
   logic [15:0] rd_v;
   logic [15:0] lq [4] = '{16'h00f3, 16'h000e, 16'h2a00, 16'h0000};
   logic [2:0]  fl [4] = '{3'h1, 3'h2, 3'h4, 3'h7};
   logic [15:0] cw [4] = '{16'h0003, 16'h0005, 16'h0011, 16'h0011};
   always #5 ref_clk = ~ref_clk;
   cri_host #(.POLL_CYCLES(4)) cri_host_inst (
      .ref_clk(ref_clk), .rst_b(rst_b), .sw_addr(sw_addr), .sw_wdata(sw_wdata),
      .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata), .mem_addr(mem_addr),
      .mem_wdata(mem_wdata), .mem_wr(mem_wr), .mem_rd(mem_rd), .mem_rdata(mem_rdata));
   cri_dev cri_dev_inst (.ref_clk(ref_clk), .hold_cyc(hold_cyc), .mem_addr(mem_addr),
      .mem_wdata(mem_wdata), .mem_wr(mem_wr), .mem_rd(mem_rd), .mem_rdata(mem_rdata));
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      n_tests++;
      if (got !== exp) begin
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
         bad_count++;
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge ref_clk);
      sw_addr <= a;
      sw_wdata <= d;
      sw_wr <= 1'b1;
      @(posedge ref_clk);
      sw_wr <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, output logic [15:0] d);
      @(posedge ref_clk);
      sw_addr <= a;
      sw_rd <= 1'b1;
      @(posedge ref_clk);
      sw_rd <= 1'b0;
      #1 d = sw_rdata;
   endtask
   task automatic rdchk(input logic [3:0] a, input logic [15:0] e);
      rd(a, rd_v);
      check(rd_v, e);
   endtask
   task automatic go(input logic [15:0] lenq, input logic [2:0] f, input logic q);
      wr(`CRI_R_LEN_Q, lenq);
      wr(`CRI_R_FLAGS, {13'h0000, f});
      nl = cri_dev_inst.n_launch;
      wr(`CRI_R_CTRL, {14'h0000, q, 1'b1});
   endtask
   // Busy stays up until the device frees the slot
   task automatic waitidle;
      repeat (4) @(posedge ref_clk);
      rd_v = 16'h0001;
      for (int i = 0; i < 300 && rd_v[0] !== 1'b0; i++) rd(`CRI_R_STATUS, rd_v);
      check(rd_v & 16'h000f, 16'h0004);
   endtask
   task automatic slot_chk(input logic [15:0] a, input logic [15:0] c0, input logic [15:0] l4);
      check({7'h00, cri_dev_inst.lidx, 1'b0}, a);
      check(cri_dev_inst.copy_w[0], c0);
      check(cri_dev_inst.copy_w[1], 16'h0200);
      check(cri_dev_inst.copy_w[2], 16'hbeef);
      check(cri_dev_inst.copy_w[3], 16'h1234);
      check(cri_dev_inst.copy_w[4], l4);
      check(cri_dev_inst.copy_w[5], 16'h0000);
      check(cri_dev_inst.mem[a[8:1]], c0 & 16'hfffe);
   endtask
   initial begin
      repeat (20000) @(posedge ref_clk);
      bad_count++;
      report_and_stop;
   end
   initial begin
      repeat (16) @(posedge ref_clk);
      rst_b <= 1'b1;
      rdchk(`CRI_R_RING_BASE, 16'h0000);
      rdchk(`CRI_R_RING_COUNT, 16'h0001);
      rdchk(`CRI_R_STATUS, 16'h0000);
      rdchk(4'hf, 16'h0000);
      wr(`CRI_R_MASTER_BASE, 16'h0040);
      wr(`CRI_R_BLK_LOC, 16'h0200);
      wr(`CRI_R_TAG_HI, 16'hbeef);
      wr(`CRI_R_TAG_LO, 16'h1234);
      go(16'h0305, 3'h0, 1'b0);
      waitidle;
      slot_chk(16'h0040, 16'h0001, 16'h0305);
      wr(`CRI_R_RING_BASE, 16'h0100);
      wr(`CRI_R_RING_COUNT, 16'h0000);
      rdchk(`CRI_R_RING_COUNT, 16'h0001);
      wr(`CRI_R_RING_COUNT, 16'h0003);
      // Four commands wrap a three-slot ring; odd ones meet a slow device
      for (int k = 0; k < 4; k++) begin
         hold_cyc <= (k % 2) ? 8'h14 : 8'h00;
         go(lq[k], fl[k], 1'b1);
         waitidle;
         slot_chk(16'h0100 + 16'(k % 3) * 16'h000c, cw[k], lq[k] & 16'hff0f);
      end
      rdchk(`CRI_R_SLOT_IDX, 16'h0001);
      go(16'h000f, 3'h0, 1'b1);
      repeat (20) @(posedge ref_clk);
      rd(`CRI_R_STATUS, rd_v);
      check(rd_v & 16'h0008, 16'h0008);
      check(16'(cri_dev_inst.n_launch - nl), 16'h0000);
      // Next slot still owned by the device: host must wait
      #1 cri_dev_inst.mem[8'h86] = 16'h0001;
      go(16'h0001, 3'h0, 1'b1);
      repeat (30) @(posedge ref_clk);
      rd(`CRI_R_STATUS, rd_v);
      check(rd_v & 16'h0002, 16'h0002);
      check(16'(cri_dev_inst.n_launch - nl), 16'h0000);
      #1 cri_dev_inst.mem[8'h86] = 16'h0000;
      waitidle;
      slot_chk(16'h010c, 16'h0001, 16'h0001);
      report_and_stop;
   end
endmodule
